// ---- dsm_pkg.sv ----
// Shared constants and types for the door state machine sampler.
// Assumes a single 25 MHz core clock and a synchronous active-high reset.
package dsm_pkg;

  // ==========================================================================
  // Clock and sampling counter
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_MATCH_VALUE = 50000;
  localparam int SAMPLE_CNT_W = 16;
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_CNT_RESET = 16'h0000;
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_CNT_STEP = 16'h0001;
  localparam logic COUNT_ENABLE_SETTING = 1'b1;
  localparam logic COUNT_DIRECTION_SETTING = 1'b1;

  // ==========================================================================
  // Door states
  typedef enum logic [1:0] {
    DSM_CLOSED,
    DSM_OPENING,
    DSM_OPENED,
    DSM_CLOSING
  } dsm_state_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic button_input;
    logic sensor_input;
  } dsm_inputs_t;

  typedef struct packed {
    logic state_bit_a;
    logic state_bit_b;
    logic move_start;
  } dsm_status_t;

  localparam dsm_status_t STATUS_RESET = 3'h0;

endpackage

// ---- dsm_door_sampler.sv ----
// Door state machine with tick-sampled button and sensor inputs.
// Holds the sampling counter, the two sample gates and the four-state door controller.
// Assumes raw inputs are asynchronous pins; one clock core_clk, reset srst.
// Assumes the downstream drive logic reads status.move_start as a one-cycle pulse.
`timescale 1ns/1ps

module dsm_door_sampler #(
  parameter int TICK_PERIOD = dsm_pkg::TICK_MATCH_VALUE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Raw external inputs
  input wire dsm_pkg::dsm_inputs_t raw_in,
  // Door status
  output dsm_pkg::dsm_status_t status
);
  import dsm_pkg::*;

  // ==========================================================================
  // State bit encodings (bit a, bit b)
  localparam logic [1:0] BITS_CLOSED = 2'h0;
  localparam logic [1:0] BITS_OPENING = 2'h2;
  localparam logic [1:0] BITS_OPENED = 2'h3;
  localparam logic [1:0] BITS_CLOSING = 2'h1;

  // ==========================================================================
  // Encoding helpers
  function automatic logic [1:0] state_bits(input dsm_state_t s);
    logic [1:0] b;
    b = BITS_CLOSED;
    unique case (s)
      DSM_CLOSED: b = BITS_CLOSED;
      DSM_OPENING: b = BITS_OPENING;
      DSM_OPENED: b = BITS_OPENED;
      DSM_CLOSING: b = BITS_CLOSING;
    endcase
    return b;
  endfunction

  function automatic logic is_moving(input dsm_state_t s);
    return (s == DSM_OPENING) || (s == DSM_CLOSING);
  endfunction

  function automatic logic is_resting(input dsm_state_t s);
    return (s == DSM_CLOSED) || (s == DSM_OPENED);
  endfunction

  function automatic logic sample_gate(input logic tick, input logic level);
    return tick & level;
  endfunction

  // ==========================================================================
  // Input synchronisers, first stage
  dsm_inputs_t sync_a;

  always_ff @(posedge core_clk) begin
    sync_a <= raw_in;
  end

  // ==========================================================================
  // Input synchronisers, second stage
  dsm_inputs_t sync_b;

  always_ff @(posedge core_clk) begin
    sync_b <= sync_a;
  end

  wire button_synced = sync_b.button_input;
  wire sensor_synced = sync_b.sensor_input;

  // ==========================================================================
  // Sampling counter step
  localparam logic [SAMPLE_CNT_W-1:0] TICK_LAST = SAMPLE_CNT_W'(TICK_PERIOD - 1);

  logic [SAMPLE_CNT_W-1:0] sample_counter;
  logic [SAMPLE_CNT_W-1:0] next_sample_counter;

  wire count_at_match = (sample_counter == TICK_LAST);
  wire sample_tick = COUNT_ENABLE_SETTING && count_at_match;

  wire [SAMPLE_CNT_W-1:0] count_up = sample_counter + SAMPLE_CNT_STEP;
  wire [SAMPLE_CNT_W-1:0] count_down = sample_counter - SAMPLE_CNT_STEP;
  wire [SAMPLE_CNT_W-1:0] count_stepped = COUNT_DIRECTION_SETTING ? count_up : count_down;
  wire [SAMPLE_CNT_W-1:0] count_held = COUNT_ENABLE_SETTING ? count_stepped : sample_counter;
  assign next_sample_counter = sample_tick ? SAMPLE_CNT_RESET : count_held;

  // ==========================================================================
  // Sampling counter register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sample_counter <= SAMPLE_CNT_RESET;
    end else begin
      sample_counter <= next_sample_counter;
    end
  end

  // ==========================================================================
  // Sample gates
  wire button_sample_gate = sample_gate(sample_tick, button_synced);
  wire sensor_sample_gate = sample_gate(sample_tick, sensor_synced);

  // ==========================================================================
  // Sampled input carrier
  dsm_inputs_t sampled;
  assign sampled = {button_sample_gate, sensor_sample_gate};

  // ==========================================================================
  // Current state decode
  dsm_state_t door_state_machine;
  dsm_state_t next_state;

  wire in_closed = (door_state_machine == DSM_CLOSED);
  wire in_opened = (door_state_machine == DSM_OPENED);
  wire in_opening = (door_state_machine == DSM_OPENING);
  wire in_closing = (door_state_machine == DSM_CLOSING);

  wire moving_now = is_moving(door_state_machine);
  wire resting_now = is_resting(door_state_machine);

  // ==========================================================================
  // Transition decode
  wire both_sampled = sampled.button_input && sampled.sensor_input;
  wire press_taken = sampled.button_input && resting_now;
  wire arrive_taken = sampled.sensor_input && !sampled.button_input && moving_now;
  wire reverse_taken = both_sampled && moving_now;

  wire go_opening = (in_closed && press_taken) || (in_closing && reverse_taken);
  wire go_closing = (in_opened && press_taken) || (in_opening && reverse_taken);
  wire go_opened = in_opening && arrive_taken;
  wire go_closed = in_closing && arrive_taken;

  // ==========================================================================
  // Door state machine
  always_comb begin
    next_state = door_state_machine;
    unique case (door_state_machine)
      DSM_CLOSED: begin
        if (go_opening) begin
          next_state = DSM_OPENING;
        end else begin
          next_state = door_state_machine;
        end
      end
      DSM_OPENED: begin
        if (go_closing) begin
          next_state = DSM_CLOSING;
        end else begin
          next_state = door_state_machine;
        end
      end
      DSM_OPENING: begin
        if (go_closing) begin
          next_state = DSM_CLOSING;
        end else if (go_opened) begin
          next_state = DSM_OPENED;
        end else begin
          next_state = door_state_machine;
        end
      end
      DSM_CLOSING: begin
        if (go_opening) begin
          next_state = DSM_OPENING;
        end else if (go_closed) begin
          next_state = DSM_CLOSED;
        end else begin
          next_state = door_state_machine;
        end
      end
    endcase
  end

  // ==========================================================================
  // Door state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      door_state_machine <= DSM_CLOSED;
    end else begin
      door_state_machine <= next_state;
    end
  end

  // ==========================================================================
  // Entry detection
  wire enter_opening = (next_state == DSM_OPENING) && !in_opening;
  wire enter_closing = (next_state == DSM_CLOSING) && !in_closing;
  wire next_move_start = enter_opening || enter_closing;

  // ==========================================================================
  // Status encode
  wire [1:0] next_bits = state_bits(next_state);
  wire next_bit_a = next_bits[1];
  wire next_bit_b = next_bits[0];
  dsm_status_t next_status;
  assign next_status = {next_bit_a, next_bit_b, next_move_start};

  // ==========================================================================
  // Status register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

endmodule

// ---- dsm_door_sampler_sva.sv ----
// Checker on the door sampler ports.
// Assumes TICK_PERIOD equals the bound instance's value.
`timescale 1ns/1ps
module dsm_door_sampler_sva #(parameter int TICK_PERIOD = 8) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins and status
  input wire dsm_pkg::dsm_inputs_t raw_in,
  input wire dsm_pkg::dsm_status_t status
);
  int cnt;
  logic [1:0] st;
  logic tk;
  assign st = {status.state_bit_a, status.state_bit_b};
  assign tk = cnt == TICK_PERIOD - 1;
  always_ff @(posedge core_clk) cnt <= (srst || tk) ? 0 : cnt + 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_hold; !tk |=> $stable(st); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_tick; status.move_start |-> $past(tk); endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_mov; status.move_start |-> st[1] ^ st[0]; endproperty
  a_mov: assert property (p_mov) else $error("mov");
  property p_ent; st != $past(st) && st[1] != st[0] |-> status.move_start; endproperty
  a_ent: assert property (p_ent) else $error("ent");
  property p_cl; $past(st) == 2'h0 && st != 2'h0 |-> st == 2'h2; endproperty
  a_cl: assert property (p_cl) else $error("cl");
  property p_op; $past(st) == 2'h3 && st != 2'h3 |-> st == 2'h1; endproperty
  a_op: assert property (p_op) else $error("op");
  property p_og; $past(st) == 2'h2 |-> st != 2'h0; endproperty
  a_og: assert property (p_og) else $error("og");
  property p_cg; $past(st) == 2'h1 |-> st != 2'h3; endproperty
  a_cg: assert property (p_cg) else $error("cg");
endmodule
bind dsm_door_sampler dsm_door_sampler_sva #(.TICK_PERIOD(TICK_PERIOD)) dsm_door_sampler_sva_inst (
  .core_clk(core_clk), .srst(srst), .raw_in(raw_in), .status(status));

// ---- dsm_pins.sv ----
// Pin model: button and sensor levels.
// Assumes the bench sets cmd; pins carry no bounce.
`timescale 1ns/1ps
module dsm_pins (
  // Requested levels: button, sensor
  input wire logic [1:0] cmd,
  // Pins
  output dsm_pkg::dsm_inputs_t raw_in
);
  assign raw_in = cmd;
endmodule

// ---- dsm_door_sampler_bench.sv ----
// Door sampler bench: tick table, then reset and glitch cases.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
module dsm_door_sampler_bench;
  import dsm_pkg::*;
  localparam int P = 8;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] cmd = 2'h0;
  dsm_inputs_t raw_in;
  dsm_status_t status;
  int errors = 0;
  int checks_done = 0;
  // Rows: button, sensor, state a, state b, move_start
  logic [4:0] rows [10] = '{5'h00, 5'h08, 5'h15, 5'h14, 5'h1B, 5'h1D, 5'h0E, 5'h13, 5'h08, 5'h1D};
  dsm_pins dsm_pins_inst (.cmd(cmd), .raw_in(raw_in));
  dsm_door_sampler #(.TICK_PERIOD(P)) dsm_door_sampler_inst (.core_clk(core_clk), .srst(srst), .raw_in(raw_in),
    .status(status));
  initial forever #20 core_clk = ~core_clk;
  task automatic check(input logic [2:0] want);
    checks_done++;
    if (status !== want) begin
      errors++;
      $display("CHECK FAILED status expected %h seen %h", want, status);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (400) @(posedge core_clk);
    errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    cmd <= rows[0][4:3];
    for (int i = 0; i < 10; i++) begin
      repeat (P) @(posedge core_clk);
      if (i < 9) cmd <= rows[i + 1][4:3];
      #1 check(rows[i][2:0]);
    end
    $display("table done");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check(STATUS_RESET);
    $display("reset done");
    @(posedge core_clk);
    srst <= 1'b0;
    cmd <= 2'h2;
    repeat (2) @(posedge core_clk);
    cmd <= 2'h0;
    repeat (P) @(posedge core_clk);
    #1 check(3'h0);
    $display("glitch done");
    @(posedge core_clk);
    cmd <= 2'h2;
    repeat (4) @(posedge core_clk);
    #1 check(3'h0);
    @(posedge core_clk);
    #1 check(3'h5);
    $display("phase done");
    stop_test();
  end
endmodule
